/* File: pkg/cbt_map.svh */
/*
  Constants of the bit timing and receive handoff block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH

// ----------------------------------------
// message handoff
// ----------------------------------------
`define CBT_MSG_WORDS 8
`define CBT_WORD_W 16

// ----------------------------------------
// bit timing
// ----------------------------------------
`define CBT_SYNC_TQ 5'h01
`define CBT_TQ_MIN 5'h08
`define CBT_TQ_MAX 5'h19
`define CBT_BRP_W 6
`define CBT_SEG_W 3
`define CBT_SJW_W 2

`endif

/* File: pkg/cbt_pkg.sv */
/*
  Types shared by the bit timing and receive handoff block.
  Assumes nothing of its surroundings.
*/
package cbt_pkg;

  typedef enum logic [1:0] {
    CBT_SEG_SYNC,
    CBT_SEG_PROP,
    CBT_SEG_PH1,
    CBT_SEG_PH2
  } cbt_seg_t;

  typedef logic [3:0] cbt_len_t;

endpackage : cbt_pkg

/* File: core/cbt_msg_ram.sv */
/*
  Small message memory: one write port, one read port, registered read data.
  Assumes a single clock and that write and read never target the same word
  in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module cbt_msg_ram #(
  parameter int WORD_W = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // write side
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WORD_W-1:0] wr_data_in,
  // read side
  input wire logic rd_en_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WORD_W-1:0] rd_data_out
);

  logic [WORD_W-1:0] mem_reg [DEPTH];

  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else if (rd_en_in) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end

endmodule : cbt_msg_ram

`default_nettype wire

/* File: core/cbt_top.sv */
/*
  Bit timing engine and receive message handoff of a bus controller.
  Assumes all inputs synchronous to mclk_in, a frame tracker that pulses
  frame_end_in, and a word-wide DMA channel that pulses dma_read_in.
*/
// Contract
// [R1] finished message raises a one-cycle receive data request for the DMA channel
// [R2] each message is handed over as eight 16-bit words read in turn
// [R3] DMA channel set for word, peripheral-to-RAM, source 34, count 7
// [R4] total quanta per bit must lie between 8 and 25
// [R5] bit divides into sync, propagation, phase one, phase two in order
// [R6] sync segment lasts one quantum; edges are expected inside it
// [R7] phase two length is programmed or derived from phase one
// [R8] bus is sampled at the phase one to phase two boundary
// [R9] triple sampling takes the majority of three samples, else one
// [R10] recessive-to-dominant start edge hard-synchronises once per frame
// [R11] edge outside sync segment resynchronises one phase segment
// [R12] late edge lengthens phase one
// [R13] early edge shortens phase two
// [R14] adjustment limited to jump width of 1 to 4 quanta
// [R15] software keeps jump width no longer than phase two
// [R16] clock select cleared makes timing clock equal system clock
// [R17] software picks quantum rate as an integer multiple of bit rate
// [R18] quantum period is twice (prescaler plus one) timing clocks
// [R19] software keeps propagation plus phase one at least phase two
// [R20] software keeps phase two longer than jump width
// [R21] transmit level changes at sync start and holds a full bit
`include "cbt_map.svh"
`timescale 1ns/1ns
`default_nettype none

module cbt_top #(
  parameter int WORD_W = `CBT_WORD_W,
  parameter int MSG_WORDS = `CBT_MSG_WORDS,
  parameter int AW = $clog2(MSG_WORDS)
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // timing configuration
  input wire logic can_clock_source_select_in,
  input wire logic [`CBT_BRP_W-1:0] baud_prescaler_in,
  input wire logic [`CBT_SJW_W-1:0] sync_jump_width_in,
  input wire logic [`CBT_SEG_W-1:0] prop_seg_in,
  input wire logic [`CBT_SEG_W-1:0] phase1_seg_in,
  input wire logic [`CBT_SEG_W-1:0] phase2_seg_in,
  input wire logic phase2_programmable_in,
  input wire logic triple_sample_select_in,
  // bus pins and frame status
  input wire logic can_rx_in,
  input wire logic tx_bit_in,
  input wire logic tx_enable_in,
  input wire logic frame_end_in,
  output logic can_tx_out,
  output logic rx_bit_out,
  output logic sample_strobe_out,
  output logic bit_start_out,
  output logic in_frame_out,
  output logic cfg_error_out,
  output cbt_pkg::cbt_seg_t segment_out,
  // received words from the controller
  input wire logic rx_word_we_in,
  input wire logic [WORD_W-1:0] rx_word_in,
  // dma side
  input wire logic dma_read_in,
  output logic rx_dma_request_out,
  output logic rx_busy_out,
  output logic [WORD_W-1:0] receive_data_port_out
);
  import cbt_pkg::*;

  // ----------------------------------------
  // receive handoff
  // ----------------------------------------
  logic [AW-1:0] wr_idx_reg;
  logic [AW-1:0] rd_idx_reg;
  logic wr_ok;
  logic rd_ok;
  logic last_wr;
  logic last_rd;

  assign wr_ok = rx_word_we_in && !rx_busy_out;
  assign rd_ok = dma_read_in && rx_busy_out;
  assign last_wr = wr_ok && (wr_idx_reg == AW'(MSG_WORDS - 1));
  assign last_rd = rd_ok && (rd_idx_reg == AW'(MSG_WORDS - 1));

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_idx_reg <= '0;
      rd_idx_reg <= '0;
      rx_busy_out <= 1'b0;
      rx_dma_request_out <= 1'b0;
    end else begin
      rx_dma_request_out <= last_wr; // R1
      if (wr_ok) begin
        wr_idx_reg <= last_wr ? '0 : wr_idx_reg + 1'b1; // R2
      end
      if (rd_ok) begin
        rd_idx_reg <= last_rd ? '0 : rd_idx_reg + 1'b1; // R2
      end
      if (last_wr) begin
        rx_busy_out <= 1'b1;
      end else if (last_rd) begin
        rx_busy_out <= 1'b0;
      end
    end
  end

  cbt_msg_ram #(
    .WORD_W(WORD_W),
    .DEPTH(MSG_WORDS),
    .AW(AW)
  ) u_ram (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wr_en_in(wr_ok),
    .wr_addr_in(wr_idx_reg),
    .wr_data_in(rx_word_in),
    .rd_en_in(rd_ok),
    .rd_addr_in(rd_idx_reg),
    .rd_data_out(receive_data_port_out)
  );

  // ----------------------------------------
  // quantum clock
  // ----------------------------------------
  logic half_reg;
  logic can_tick;
  logic [6:0] pre_cnt_reg;
  logic [6:0] pre_lim;
  logic tq_tick;
  logic hard_sync;

  assign can_tick = can_clock_source_select_in ? half_reg : 1'b1; // R16
  assign pre_lim = {baud_prescaler_in, 1'b1}; // R18
  assign tq_tick = can_tick && (pre_cnt_reg == pre_lim) && !hard_sync;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      half_reg <= 1'b0;
      pre_cnt_reg <= '0;
    end else begin
      half_reg <= !half_reg && !hard_sync;
      if (hard_sync) begin
        pre_cnt_reg <= '0;
      end else if (can_tick) begin
        pre_cnt_reg <= (pre_cnt_reg == pre_lim) ? '0 : pre_cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // segment lengths
  // ----------------------------------------
  cbt_len_t prop_len;
  cbt_len_t ph1_len;
  cbt_len_t ph2_len;
  cbt_len_t sjw_len;
  logic [4:0] total_len;
  logic cfg_bad;

  assign prop_len = {1'b0, prop_seg_in} + 4'h1;
  assign ph1_len = {1'b0, phase1_seg_in} + 4'h1;
  assign ph2_len = phase2_programmable_in ? {1'b0, phase2_seg_in} + 4'h1 : ph1_len; // R7
  assign sjw_len = {2'h0, sync_jump_width_in} + 4'h1; // R14
  assign total_len = `CBT_SYNC_TQ + {1'b0, prop_len} + {1'b0, ph1_len} + {1'b0, ph2_len}; // R5
  assign cfg_bad = (total_len < `CBT_TQ_MIN) || (total_len > `CBT_TQ_MAX); // R4

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_error_out <= 1'b0;
    end else begin
      cfg_error_out <= cfg_bad; // R4
    end
  end

  // ----------------------------------------
  // edges and frame tracking
  // ----------------------------------------
  logic bus_prev_reg;
  logic tq_bus_reg;
  logic s1_reg;
  logic s2_reg;
  logic majority;

  assign hard_sync = !in_frame_out && bus_prev_reg && !can_rx_in && !cfg_error_out; // R10
  assign majority = (can_rx_in & s1_reg) | (can_rx_in & s2_reg) | (s1_reg & s2_reg);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_prev_reg <= 1'b1;
      tq_bus_reg <= 1'b1;
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      bus_prev_reg <= can_rx_in;
      s1_reg <= can_rx_in;
      s2_reg <= s1_reg;
      if (tq_tick || hard_sync) begin
        tq_bus_reg <= can_rx_in;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      in_frame_out <= 1'b0;
    end else if (hard_sync) begin
      in_frame_out <= 1'b1; // R10
    end else if (frame_end_in || cfg_error_out) begin
      in_frame_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // segment sequencer and resynchronisation
  // ----------------------------------------
  cbt_len_t cnt_reg;
  cbt_len_t ext_reg;
  cbt_len_t shr_reg;
  cbt_len_t ext_next;
  cbt_len_t shr_next;
  cbt_len_t remain;
  logic [4:0] late_err;
  logic resynced_reg;
  logic tq_edge;
  logic late;
  logic early;
  logic early_jump;
  logic ph1_done;
  logic ph2_done;
  logic bit_start;

  assign tq_edge = tq_tick && tq_bus_reg && !can_rx_in && in_frame_out && !resynced_reg && !cfg_error_out;
  assign late = tq_edge && (segment_out == CBT_SEG_PROP || segment_out == CBT_SEG_PH1); // R11
  assign early = tq_edge && (segment_out == CBT_SEG_PH2); // R11
  assign late_err = (segment_out == CBT_SEG_PROP) ? {1'b0, cnt_reg} + 5'h01
                                                 : {1'b0, prop_len} + {1'b0, cnt_reg} + 5'h01;
  assign ext_next = !late ? ext_reg : (late_err < {1'b0, sjw_len}) ? late_err[3:0] : sjw_len; // R12 R14
  assign remain = ph2_len - cnt_reg;
  assign early_jump = early && (remain <= sjw_len); // R13
  assign shr_next = (early && !early_jump) ? sjw_len : shr_reg; // R13 R14
  assign ph1_done = tq_tick && (segment_out == CBT_SEG_PH1) && (cnt_reg + 4'h1 >= ph1_len + ext_next);
  assign ph2_done = tq_tick && (segment_out == CBT_SEG_PH2) && !early_jump
                    && (cnt_reg + 4'h1 + shr_next >= ph2_len);
  assign bit_start = hard_sync || ph2_done || early_jump;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      segment_out <= CBT_SEG_SYNC;
      cnt_reg <= '0;
      ext_reg <= '0;
      shr_reg <= '0;
      resynced_reg <= 1'b0;
    end else if (cfg_error_out) begin
      segment_out <= CBT_SEG_SYNC;
      cnt_reg <= '0;
      ext_reg <= '0;
      shr_reg <= '0;
      resynced_reg <= 1'b0;
    end else if (hard_sync) begin
      segment_out <= CBT_SEG_SYNC; // R10
      cnt_reg <= '0;
      ext_reg <= '0;
      shr_reg <= '0;
      resynced_reg <= 1'b1;
    end else if (tq_tick) begin
      ext_reg <= ext_next;
      shr_reg <= shr_next;
      if (late || early) begin
        resynced_reg <= 1'b1;
      end
      unique case (segment_out)
        CBT_SEG_SYNC: begin
          segment_out <= CBT_SEG_PROP; // R5 R6
          cnt_reg <= '0;
          ext_reg <= '0;
          shr_reg <= '0;
          resynced_reg <= 1'b0;
        end
        CBT_SEG_PROP: begin
          if (cnt_reg + 4'h1 >= prop_len) begin
            segment_out <= CBT_SEG_PH1; // R5
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        CBT_SEG_PH1: begin
          if (ph1_done) begin
            segment_out <= CBT_SEG_PH2; // R5 R8
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        CBT_SEG_PH2: begin
          if (early_jump) begin
            segment_out <= CBT_SEG_PROP; // R13
            cnt_reg <= '0;
            ext_reg <= '0;
            shr_reg <= '0;
          end else if (ph2_done) begin
            segment_out <= CBT_SEG_SYNC; // R5
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // sampling and transmit level
  // ----------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_bit_out <= 1'b1;
      sample_strobe_out <= 1'b0;
    end else begin
      sample_strobe_out <= ph1_done && !cfg_error_out; // R8
      if (ph1_done && !cfg_error_out) begin
        rx_bit_out <= triple_sample_select_in ? majority : can_rx_in; // R9
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      can_tx_out <= 1'b1;
      bit_start_out <= 1'b0;
    end else begin
      bit_start_out <= bit_start && !cfg_error_out;
      if (cfg_error_out) begin
        can_tx_out <= 1'b1;
      end else if (bit_start) begin
        can_tx_out <= tx_enable_in ? tx_bit_in : 1'b1; // R21
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_rx_request;
    @(posedge mclk_in) disable iff (rst_in)
    last_wr |=> rx_dma_request_out && rx_busy_out ##1 !rx_dma_request_out;
  endproperty
  a_rx_request: assert property (p_rx_request) // R1
    else $error("receive request not raised after last word");

  property p_rx_drain;
    @(posedge mclk_in) disable iff (rst_in)
    last_rd |=> !rx_busy_out && rd_idx_reg == '0;
  endproperty
  a_rx_drain: assert property (p_rx_drain) // R2
    else $error("buffer not released after eighth read");

  property p_sync_one;
    @(posedge mclk_in) disable iff (rst_in)
    tq_tick && segment_out == CBT_SEG_SYNC && !cfg_error_out |=> segment_out == CBT_SEG_PROP;
  endproperty
  a_sync_one: assert property (p_sync_one) // R6
    else $error("sync segment longer than one quantum");

  property p_order;
    @(posedge mclk_in) disable iff (rst_in)
    segment_out == CBT_SEG_PROP && !cfg_error_out && !hard_sync |=> segment_out inside {CBT_SEG_PROP, CBT_SEG_PH1};
  endproperty
  a_order: assert property (p_order) // R5
    else $error("propagation segment left out of order");

  property p_majority;
    @(posedge mclk_in) disable iff (rst_in)
    ph1_done && triple_sample_select_in && !cfg_error_out |=> rx_bit_out == $past(majority) && sample_strobe_out;
  endproperty
  a_majority: assert property (p_majority) // R9
    else $error("triple sample not the majority");

  property p_hard_sync;
    @(posedge mclk_in) disable iff (rst_in)
    hard_sync |=> segment_out == CBT_SEG_SYNC && in_frame_out && bit_start_out;
  endproperty
  a_hard_sync: assert property (p_hard_sync) // R10
    else $error("hard sync did not restart the bit");

  property p_jump_limit;
    @(posedge mclk_in) disable iff (rst_in)
    ext_reg <= sjw_len && shr_reg <= sjw_len;
  endproperty
  a_jump_limit: assert property (p_jump_limit) // R14
    else $error("phase adjustment beyond jump width");

  property p_late;
    @(posedge mclk_in) disable iff (rst_in)
    late && !ph1_done |=> ext_reg != '0 && resynced_reg;
  endproperty
  a_late: assert property (p_late) // R12
    else $error("late edge did not lengthen phase one");

  property p_early;
    @(posedge mclk_in) disable iff (rst_in)
    early && !early_jump |=> shr_reg == $past(sjw_len);
  endproperty
  a_early: assert property (p_early) // R13
    else $error("early edge did not shorten phase two");

  property p_tx_hold;
    @(posedge mclk_in) disable iff (rst_in)
    !bit_start && !cfg_error_out |=> $stable(can_tx_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) // R21
    else $error("transmit level changed inside a bit");

  property p_tq_spacing;
    @(posedge mclk_in) disable iff (rst_in)
    tq_tick && !can_clock_source_select_in |=> !tq_tick;
  endproperty
  a_tq_spacing: assert property (p_tq_spacing) // R18
    else $error("quantum shorter than two clocks");

  property p_cfg_hold;
    @(posedge mclk_in) disable iff (rst_in)
    cfg_error_out |=> segment_out == CBT_SEG_SYNC && !sample_strobe_out;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) // R4
    else $error("engine ran with illegal bit length");

endmodule : cbt_top

`default_nettype wire

/* File: bench/cbt_bus_node.sv */
/*
  Bus node model: another station on the wire, dominant 0 or released 1.
  Assumes the bench ANDs its output with the block's transmit level.
*/
`timescale 1ns/1ns
`default_nettype none

module cbt_bus_node (
  // clock
  input wire logic mclk_in,
  // wire drive, 1 releases to the pull-up
  output logic bus_drv_out
);
  initial bus_drv_out = 1'h1;

  // ----------------------------------------
  // level changes land just after an edge, on whole cycles
  // ----------------------------------------
  task automatic level_after(input int n, input logic lvl);
    repeat (n) @(posedge mclk_in);
    if (n > 0) #1;
    bus_drv_out = lvl;
  endtask : level_after
endmodule : cbt_bus_node

`default_nettype wire

/* File: bench/test_cbt_top.sv */
/*
  Self-checking bench of the bit timing engine and receive handoff.
  Assumes the bus node model and a wired-AND bus with pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module test_cbt_top;
  import cbt_pkg::*;
  logic mclk_in = 1'h0, rst_in = 1'h1, sel = 1'h0, prog = 1'h1, triple_sample_select = 1'h0;
  logic tx_bit = 1'h0, tx_en = 1'h0, fend = 1'h0, we = 1'h0, rd = 1'h0;
  logic [5:0] baud_prescaler = 6'h00;
  logic [1:0] sync_jump_width = 2'h0;
  logic [2:0] prop = 3'h0, ph1 = 3'h2, ph2 = 3'h2;
  logic [15:0] word = 16'h0000, rdata;
  logic can_tx, rx_bit, strobe, bstart, in_frame, cfg_err, req, busy, node_drv;
  wire logic can_rx;
  cbt_seg_t seg;
  int seed = 13, num_errors = 0, n_compared = 0, cyc = 0;
  int bs[$], ss[$];
  logic [15:0] w[8];

  assign can_rx = node_drv & can_tx;

  cbt_bus_node node (.mclk_in(mclk_in), .bus_drv_out(node_drv));

  cbt_top DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .can_clock_source_select_in(sel),
    .baud_prescaler_in(baud_prescaler), .sync_jump_width_in(sync_jump_width), .prop_seg_in(prop),
    .phase1_seg_in(ph1), .phase2_seg_in(ph2), .phase2_programmable_in(prog),
    .triple_sample_select_in(triple_sample_select), .can_rx_in(can_rx), .tx_bit_in(tx_bit),
    .tx_enable_in(tx_en), .frame_end_in(fend), .can_tx_out(can_tx), .rx_bit_out(rx_bit),
    .sample_strobe_out(strobe), .bit_start_out(bstart), .in_frame_out(in_frame),
    .cfg_error_out(cfg_err), .segment_out(seg), .rx_word_we_in(we), .rx_word_in(word),
    .dma_read_in(rd), .rx_dma_request_out(req), .rx_busy_out(busy),
    .receive_data_port_out(rdata)
  );

  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cyc <= cyc + 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick

  task automatic wait_pulse(input bit strb);
    for (int i = 0; i < 900; i++) begin
      tick(1);
      if ((strb ? strobe : bstart) === 1'h1) return;
    end
    num_errors++;
  endtask : wait_pulse

  task automatic end_frame;
    node.level_after(0, 1'h1);
    fend = 1'h1;
    tick(1);
    fend = 1'h0;
    tick(2);
    chk(in_frame, 1'h0);
  endtask : end_frame

  // in-frame bit starts and sample points, with the segment seen there
  always @(posedge mclk_in) begin
    #1;
    if (in_frame === 1'h1 && bstart === 1'h1) begin
      bs.push_back(cyc);
      chk(seg, CBT_SEG_SYNC);
    end
    if (in_frame === 1'h1 && strobe === 1'h1) begin
      ss.push_back(cyc);
      chk(seg, CBT_SEG_PH2);
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic msg(input int gap);
    for (int i = 0; i < 8; i++) begin
      w[i] = $random(seed);
      if (i == 4 && gap > 0) begin
        we = 1'h0;
        tick(gap);
      end
      we = 1'h1;
      word = w[i];
      tick(1);
      chk(req, i == 7);
    end
    chk(busy, 1'h1);
    rd = 1'h1;
    word = ~w[0];
    for (int i = 0; i < 8; i++) begin
      tick(1);
      we = 1'h0;
      chk(rdata, w[i]);
      chk(req, 1'h0);
    end
    rd = 1'h0;
    chk(busy, 1'h0);
  endtask : msg

  task automatic cfg_run(input logic [2:0] p, a, b, input logic pg, input logic [5:0] r, input logic s);
    int q, n, off, t, len2;
    if (!pg && a == 3'h0) a = 3'h1;
    if (pg && b == 3'h0) b = 3'h1;
    if (pg && b > p + a + 1) b = p + a + 1;
    {prop, ph1, ph2, prog, baud_prescaler, sel} = {p, a, b, pg, r, s};
    len2 = pg ? b + 1 : a + 1;
    n = 3 + p + a + len2;
    q = 2 * (r + 1) * (s + 1);
    off = (3 + p + a) * q;
    sync_jump_width = len2 > 1 ? ($random(seed) & 3) % (len2 - 1) : 0;
    triple_sample_select = $random(seed);
    tick(4);
    chk(cfg_err, n < 8 || n > 25);
    if (n < 8 || n > 25) begin
      chk(seg, CBT_SEG_SYNC);
      return;
    end
    bs.delete();
    ss.delete();
    node.level_after(0, 1'h0);
    for (int i = 0; i < 20 && bs.size() == 0; i++) tick(1);
    chk(in_frame, 1'h1);
    t = bs[0] + 3 * n * q + off;
    node.level_after(t - 1 - cyc, 1'h1);
    tick(1);
    chk(strobe, 1'h1);
    chk(rx_bit, triple_sample_select ? 1'h0 : 1'h1);
    chk(ss[0] - bs[0], off);
    for (int k = 1; k < 4; k++) chk(bs[k] - bs[k-1], n * q);
    end_frame();
  endtask : cfg_run

  task automatic resync(input int shift, input int k, input int exp);
    bs.delete();
    node.level_after(0, 1'h0);
    node.level_after(24, 1'h1);
    node.level_after(24 + shift, 1'h0);
    tick(60);
    chk(bs[k] - bs[k-1], exp);
    end_frame();
  endtask : resync

  task automatic tx_run;
    wait_pulse(1);
    for (int i = 0; i < 6; i++) begin
      tx_bit = $random(seed);
      tx_en = $random(seed);
      wait_pulse(0);
      chk(can_tx, tx_en ? tx_bit : 1'h1);
      wait_pulse(1);
      chk(can_tx, tx_en ? tx_bit : 1'h1);
      chk(rx_bit, tx_en ? tx_bit : 1'h1);
    end
    tx_en = 1'h0;
    end_frame();
  endtask : tx_run

  initial begin
    repeat (4) @(posedge mclk_in);
    #1;
    rst_in = 1'h0;
    chk(can_tx, 1'h1);
    chk(rx_bit, 1'h1);
    chk(busy, 1'h0);
    msg(0);
    tick(1);
    rd = 1'h1;
    tick(1);
    rd = 1'h0;
    tick(1);
    chk(busy, 1'h0);
    msg($random(seed) & 7);
    cfg_run(3'h0, 3'h2, 3'h1, 1'h1, 6'h00, 1'h0);
    cfg_run(3'h0, 3'h2, 3'h2, 1'h1, 6'h00, 1'h0);
    cfg_run(3'h0, 3'h2, 3'h0, 1'h0, 6'h00, 1'h0);
    cfg_run(3'h7, 3'h7, 3'h7, 1'h1, 6'h00, 1'h1);
    cfg_run(3'h7, 3'h7, 3'h0, 1'h0, 6'h01, 1'h0);
    cfg_run(3'h0, 3'h0, 3'h0, 1'h1, 6'h00, 1'h0);
    for (int i = 0; i < 5; i++)
      cfg_run($random(seed), $random(seed), $random(seed), $random(seed), $random(seed) & 3, $random(seed));
    {prop, ph1, ph2, prog, baud_prescaler, sel, sync_jump_width} = {3'h2, 3'h2, 3'h4, 1'h1, 6'h00, 1'h0, 2'h0};
    tick(4);
    resync(5, 3, 26);
    resync(-6, 2, 22);
    tx_run();
    tally_and_finish();
  end

  initial begin
    #600000;
    num_errors++;
    tally_and_finish();
  end
endmodule : test_cbt_top

`default_nettype wire
